//--- rtl/mfir_defs.vh
// Constants for the multirate FIR tap-mode block
// Functional notes
// - Half rate: two coefficients per cell, two multiplies per output sample.
// - Half rate: each cell delays two samples; end accumulator sums products.
// - Half rate latency is 46 clocks dual, 62 clocks cascaded.
// - Half-rate 64-tap cascade uses second word AE28 and cascade word 5E00.
// - Coefficient base is 128 for first path or cascade, 192 for second.
// - Half rate slots 0/1: tap k at base+2k even, base+2k-1 odd.
// - Half rate slots 2/3: tap k at base+2k+2 even, base+2k+1 odd.
// - Adding 0020 to first word selects slots 2/3, switched glitch-free.
// - Quarter rate: four coefficients per cell, taps quadrupled.
// - Quarter rate: each cell delays four samples; accumulator sums products.
// - Quarter rate latency is 50 clocks dual, 66 clocks cascaded.
// - Quarter rate: tap k sits at base plus k.
// - Quarter rate has no alternate bank; write sync aligns coefficient writes.
// - Double-rate input: filtered samples leave on the first output pins.
// - Double rate uses output word 0048 and shows 44 clocks latency.
// - Double rate: even k at 128+2k+1, odd k at 192+2k-1.
// - Decimation computes every second or fourth output, multiplying taps.
// - Decimation latency 46/62 for half output, 50/66 for quarter output.
// - Decimation uses half-rate or quarter-rate coefficient mapping by output.
`ifndef MFIR_DEFS_VH
`define MFIR_DEFS_VH

// ----------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define MFIR_IDX_PCW1_A     8'h00
`define MFIR_IDX_PCW2_A     8'h01
`define MFIR_IDX_PCW1_B     8'h02
`define MFIR_IDX_PCW2_B     8'h03
`define MFIR_IDX_CASC       8'h04
`define MFIR_IDX_OUTW       8'h05
`define MFIR_IDX_CFG        8'h06
`define MFIR_IDX_STATUS     8'h07
`define MFIR_COEF_BASE_A    8'h80
`define MFIR_COEF_BASE_B    8'hC0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MFIR_BANK_BIT       5
`define MFIR_IN_HALF_BIT    14
`define MFIR_IN_QUAR_BIT    15
`define MFIR_SYNC_BIT       0
`define MFIR_OUT_HALF       2'b11
`define MFIR_OUT_QUAR       2'b10
`define MFIR_OUT_DOUBLE     16'h0048

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MFIR_RST_PCW1_A     16'h20D8
`define MFIR_RST_PCW1_B     16'h00D8
`define MFIR_RST_PCW2       16'h6000
`define MFIR_RST_CASC       16'h2000
`define MFIR_RST_OUTW       16'h0000

// ----------------------------------------------------------------------
// Latencies in clocks
// ----------------------------------------------------------------------
`define MFIR_LAT_FULL_DUAL  7'd44
`define MFIR_LAT_FULL_CASC  7'd60
`define MFIR_LAT_HALF_DUAL  7'd46
`define MFIR_LAT_HALF_CASC  7'd62
`define MFIR_LAT_QUAR_DUAL  7'd50
`define MFIR_LAT_QUAR_CASC  7'd66

`endif

//--- rtl/mfir_cell.v
// One filter cell: four coefficient slots and one tap multiplier
`timescale 1ns/1ps
`default_nettype none
module mfir_cell (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        wr_en,
    input  wire [1:0]  wr_slot,
    input  wire [15:0] wr_data,
    input  wire [1:0]  tap_slot,
    input  wire [11:0] sample,
    input  wire [1:0]  bus_slot,
    output wire [27:0] product,
    output wire [15:0] bus_coef
);
    reg [15:0] coef_q [0:3];
    integer k;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (k = 0; k < 4; k = k + 1) begin
                coef_q[k] <= 16'h0000;
            end
        end else if (wr_en) begin
            coef_q[wr_slot] <= wr_data;
        end
    end

    wire signed [15:0] coef_s = coef_q[tap_slot];
    wire signed [11:0] smp_s  = sample;
    wire signed [27:0] prod_s = coef_s * smp_s;

    assign product  = prod_s;
    assign bus_coef = coef_q[bus_slot];
endmodule
`default_nettype wire

//--- rtl/mfir_align.v
// Variable delay that pads each path to its fixed input-to-output latency
`timescale 1ns/1ps
`default_nettype none
module mfir_align (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        din_valid,
    input  wire [15:0] din_data,
    input  wire [5:0]  offset,
    output reg         dout_valid,
    output reg  [15:0] dout_data
);
    reg [15:0] mem [0:63];
    reg [63:0] vld_q;
    reg [5:0]  wp_q;
    wire [5:0] rp = wp_q - offset;

    // Data array needs no reset; valid bits keep garbage from escaping
    always @(posedge pclk) begin
        mem[wp_q] <= din_data;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q       <= 6'h00;
            vld_q      <= 64'h0000_0000_0000_0000;
            dout_valid <= 1'b0;
            dout_data  <= 16'h0000;
        end else begin
            wp_q        <= wp_q + 6'h01;
            vld_q[wp_q] <= din_valid;
            dout_valid  <= vld_q[rp];
            dout_data   <= vld_q[rp] ? mem[rp] : 16'h0000;
        end
    end
endmodule
`default_nettype wire

//--- rtl/mfir_top.v
// Multirate FIR datapath with APB control words and coefficient memory
`timescale 1ns/1ps
`default_nettype none
`include "mfir_defs.vh"
module mfir_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [11:0] in_first,
    input  wire [11:0] in_second,
    input  wire        sync_in_n,
    output wire [15:0] out_first,
    output wire        out_first_valid,
    output wire [15:0] out_second,
    output wire        out_second_valid
);
    localparam NCELL   = 16;
    localparam DLN     = 136;
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN  = 2'b10;

    // ------------------------------------------------------------------
    // Control words: bus copies and active copies
    // ------------------------------------------------------------------
    reg [15:0] pcw1a_q;
    reg [15:0] pcw2a_q;
    reg [15:0] pcw1b_q;
    reg [15:0] pcw2b_q;
    reg [15:0] casc_q;
    reg [15:0] outw_q;
    reg        cfg_q;
    reg [15:0] act_pcw1a_q;
    reg [15:0] act_pcw1b_q;
    reg [15:0] act_casc_q;
    reg [15:0] act_outw_q;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    reg  [1:0] in_log;
    reg  [1:0] out_raw;
    reg  [1:0] in_mask;
    reg  [1:0] out_mask;
    wire [1:0] out_log = (out_raw > in_log) ? out_raw : in_log;
    wire       casc    = |act_casc_q[15:14];
    wire       dbl     = (act_outw_q == `MFIR_OUT_DOUBLE);
    wire       bank_a  = act_pcw1a_q[`MFIR_BANK_BIT];
    wire       bank_b  = act_pcw1b_q[`MFIR_BANK_BIT];

    always @* begin
        if (act_pcw1a_q[`MFIR_IN_QUAR_BIT]) begin
            in_log = 2'd2;
        end else if (act_pcw1a_q[`MFIR_IN_HALF_BIT]) begin
            in_log = 2'd1;
        end else begin
            in_log = 2'd0;
        end
        case (act_pcw1a_q[1:0])
            `MFIR_OUT_HALF: out_raw = 2'd1;
            `MFIR_OUT_QUAR: out_raw = 2'd2;
            default:        out_raw = 2'd0;
        endcase
        case (in_log)
            2'd1:    in_mask = 2'b01;
            2'd2:    in_mask = 2'b11;
            default: in_mask = 2'b00;
        endcase
        case (out_log)
            2'd1:    out_mask = 2'b01;
            2'd2:    out_mask = 2'b11;
            default: out_mask = 2'b00;
        endcase
    end

    // ------------------------------------------------------------------
    // Sample phase: sync pin marks phase zero
    // ------------------------------------------------------------------
    reg  [1:0] ph_q;
    wire [1:0] ph_now  = sync_in_n ? ph_q : 2'b00;
    wire       take_in = ((ph_now & in_mask) == 2'b00);
    wire       start   = ((ph_now & out_mask) == 2'b00);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q <= 2'b00;
        end else begin
            ph_q <= ph_now + 2'b01;
        end
    end

    // ------------------------------------------------------------------
    // Delay lines, R samples per cell
    // ------------------------------------------------------------------
    reg [11:0] dla [0:DLN-1];
    reg [11:0] dlb [0:DLN-1];
    integer i;
    integer j;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < DLN; i = i + 1) begin
                dla[i] <= 12'h000;
                dlb[i] <= 12'h000;
            end
        end else if (take_in) begin
            dla[0] <= in_first;
            dlb[0] <= in_second;
            for (i = 1; i < DLN; i = i + 1) begin
                dla[i] <= dla[i-1];
                dlb[i] <= dlb[i-1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Accumulation sequencer
    // ------------------------------------------------------------------
    reg  [1:0] state_q;
    reg  [1:0] state_d;
    reg  [1:0] st_q;
    wire       run  = (state_q == ST_RUN);
    wire       done = run && (st_q == out_mask);
    // Full-rate input keeps shifting during a decimating accumulation
    wire [1:0] ex   = (in_log == 2'd0) ? st_q : 2'b00;

    always @* begin
        case (state_q)
            ST_IDLE: state_d = start ? ST_RUN : ST_IDLE;
            ST_RUN:  state_d = (start || (st_q != out_mask)) ? ST_RUN : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            st_q    <= 2'b00;
        end else begin
            state_q <= state_d;
            if (start) begin
                st_q <= 2'b00;
            end else if (run) begin
                st_q <= st_q + 2'b01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Slot selection per step
    // ------------------------------------------------------------------
    reg [1:0] slot_a;
    reg [1:0] slot_b;

    always @* begin
        case (out_log)
            2'd2: begin
                slot_a = st_q;
                slot_b = st_q;
            end
            2'd1: begin
                slot_a = {bank_a, st_q[0]};
                slot_b = {bank_b, st_q[0]};
            end
            default: begin
                slot_a = {bank_a, 1'b1};
                slot_b = {bank_b, 1'b1};
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Coefficient bus decode
    // ------------------------------------------------------------------
    wire [7:0] idx     = paddr[9:2];
    wire       addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    wire       is_coef = addr_ok && idx[7];
    wire       is_ctl  = addr_ok && !idx[7] && (idx <= `MFIR_IDX_STATUS);
    wire       is_b    = (idx >= `MFIR_COEF_BASE_B);
    wire [3:0] cell_no = idx[5:2];
    wire       setup   = psel && !penable;
    wire       access  = psel && penable;
    // Synced writes wait for a sample boundary so no output sees a half update
    wire       coef_hold = is_coef && pwrite && cfg_q && (out_log != 2'd0);
    wire       wr_go     = access && pwrite && pready;
    wire       coef_wr   = wr_go && is_coef;

    assign pready  = !coef_hold || start;
    assign pslverr = access && !(is_coef || is_ctl);

    // ------------------------------------------------------------------
    // Filter cells
    // ------------------------------------------------------------------
    wire [NCELL*28-1:0] prod_a;
    wire [NCELL*28-1:0] prod_b;
    wire [NCELL*16-1:0] rb_a;
    wire [NCELL*16-1:0] rb_b;

    genvar c;
    generate
        for (c = 0; c < NCELL; c = c + 1) begin : g_cell
            localparam [31:0] CA = c;
            localparam [31:0] CB = c + NCELL;
            wire [7:0] ia = (CA[7:0] << out_log) + {6'b0, st_q} + {6'b0, ex};
            wire [7:0] ib = ((casc ? CB[7:0] : CA[7:0]) << out_log) + {6'b0, st_q} + {6'b0, ex};
            // Cascade extends the first path's delay line into the second
            wire [11:0] smp_b = casc ? dla[ib] : dlb[ib];

            mfir_cell u_cell_a (
                .pclk     (pclk),
                .presetn  (presetn),
                .wr_en    (coef_wr && !is_b && (cell_no == CA[3:0])),
                .wr_slot  (idx[1:0]),
                .wr_data  (pwdata[15:0]),
                .tap_slot (slot_a),
                .sample   (dla[ia]),
                .bus_slot (idx[1:0]),
                .product  (prod_a[c*28 +: 28]),
                .bus_coef (rb_a[c*16 +: 16])
            );

            mfir_cell u_cell_b (
                .pclk     (pclk),
                .presetn  (presetn),
                .wr_en    (coef_wr && is_b && (cell_no == CA[3:0])),
                .wr_slot  (idx[1:0]),
                .wr_data  (pwdata[15:0]),
                .tap_slot (slot_b),
                .sample   (smp_b),
                .bus_slot (idx[1:0]),
                .product  (prod_b[c*28 +: 28]),
                .bus_coef (rb_b[c*16 +: 16])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // End-of-path accumulators
    // ------------------------------------------------------------------
    reg  [35:0] sum_a;
    reg  [35:0] sum_b;
    reg  [35:0] acc_a_q;
    reg  [35:0] acc_b_q;
    reg  [35:0] raw_a_q;
    reg  [35:0] raw_b_q;
    reg         raw_v_q;
    wire [35:0] acc_a_d = ((st_q == 2'b00) ? 36'h0_0000_0000 : acc_a_q) + sum_a;
    wire [35:0] acc_b_d = ((st_q == 2'b00) ? 36'h0_0000_0000 : acc_b_q) + sum_b;
    wire [35:0] raw_ab  = raw_a_q + raw_b_q;

    always @* begin
        sum_a = 36'h0_0000_0000;
        sum_b = 36'h0_0000_0000;
        for (j = 0; j < NCELL; j = j + 1) begin
            sum_a = sum_a + {{8{prod_a[j*28+27]}}, prod_a[j*28 +: 28]};
            sum_b = sum_b + {{8{prod_b[j*28+27]}}, prod_b[j*28 +: 28]};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_a_q <= 36'h0_0000_0000;
            acc_b_q <= 36'h0_0000_0000;
            raw_a_q <= 36'h0_0000_0000;
            raw_b_q <= 36'h0_0000_0000;
            raw_v_q <= 1'b0;
        end else begin
            raw_v_q <= done;
            if (run) begin
                acc_a_q <= acc_a_d;
                acc_b_q <= acc_b_d;
            end
            if (done) begin
                raw_a_q <= acc_a_d;
                raw_b_q <= acc_b_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // Latency alignment
    // ------------------------------------------------------------------
    reg  [6:0] lat_dual;
    reg  [6:0] lat_casc;
    wire [6:0] lat_b   = casc ? lat_casc : lat_dual;
    wire [6:0] off_a_w = lat_dual - {5'b0, out_mask} - 7'd2;
    wire [6:0] off_b_w = lat_b - {5'b0, out_mask} - 7'd2;

    always @* begin
        case (out_log)
            2'd1: begin
                lat_dual = `MFIR_LAT_HALF_DUAL;
                lat_casc = `MFIR_LAT_HALF_CASC;
            end
            2'd2: begin
                lat_dual = `MFIR_LAT_QUAR_DUAL;
                lat_casc = `MFIR_LAT_QUAR_CASC;
            end
            default: begin
                lat_dual = `MFIR_LAT_FULL_DUAL;
                lat_casc = `MFIR_LAT_FULL_CASC;
            end
        endcase
    end

    mfir_align u_align_a (
        .pclk       (pclk),
        .presetn    (presetn),
        .din_valid  (raw_v_q && !casc),
        .din_data   (dbl ? raw_ab[27:12] : raw_a_q[27:12]),
        .offset     (off_a_w[5:0]),
        .dout_valid (out_first_valid),
        .dout_data  (out_first)
    );

    mfir_align u_align_b (
        .pclk       (pclk),
        .presetn    (presetn),
        .din_valid  (raw_v_q && !dbl),
        .din_data   (casc ? raw_ab[27:12] : raw_b_q[27:12]),
        .offset     (off_b_w[5:0]),
        .dout_valid (out_second_valid),
        .dout_data  (out_second)
    );

    // ------------------------------------------------------------------
    // Register writes and boundary-aligned apply
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcw1a_q     <= `MFIR_RST_PCW1_A;
            pcw2a_q     <= `MFIR_RST_PCW2;
            pcw1b_q     <= `MFIR_RST_PCW1_B;
            pcw2b_q     <= `MFIR_RST_PCW2;
            casc_q      <= `MFIR_RST_CASC;
            outw_q      <= `MFIR_RST_OUTW;
            cfg_q       <= 1'b0;
            act_pcw1a_q <= `MFIR_RST_PCW1_A;
            act_pcw1b_q <= `MFIR_RST_PCW1_B;
            act_casc_q  <= `MFIR_RST_CASC;
            act_outw_q  <= `MFIR_RST_OUTW;
        end else begin
            if (wr_go && is_ctl) begin
                case (idx)
                    `MFIR_IDX_PCW1_A: pcw1a_q <= pwdata[15:0];
                    `MFIR_IDX_PCW2_A: pcw2a_q <= pwdata[15:0];
                    `MFIR_IDX_PCW1_B: pcw1b_q <= pwdata[15:0];
                    `MFIR_IDX_PCW2_B: pcw2b_q <= pwdata[15:0];
                    `MFIR_IDX_CASC:   casc_q  <= pwdata[15:0];
                    `MFIR_IDX_OUTW:   outw_q  <= pwdata[15:0];
                    `MFIR_IDX_CFG:    cfg_q   <= pwdata[`MFIR_SYNC_BIT];
                    default:          cfg_q   <= cfg_q;
                endcase
            end
            // Whole words take effect only at a sample boundary
            if (start) begin
                act_pcw1a_q <= pcw1a_q;
                act_pcw1b_q <= pcw1b_q;
                act_casc_q  <= casc_q;
                act_outw_q  <= outw_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data, captured in the setup phase
    // ------------------------------------------------------------------
    wire [15:0] status = {3'b000, in_log, out_log, dbl, casc, lat_dual};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            if (is_coef) begin
                prdata <= {16'h0000, is_b ? rb_b[cell_no*16 +: 16] : rb_a[cell_no*16 +: 16]};
            end else begin
                case (idx)
                    `MFIR_IDX_PCW1_A: prdata <= {16'h0000, pcw1a_q};
                    `MFIR_IDX_PCW2_A: prdata <= {16'h0000, pcw2a_q};
                    `MFIR_IDX_PCW1_B: prdata <= {16'h0000, pcw1b_q};
                    `MFIR_IDX_PCW2_B: prdata <= {16'h0000, pcw2b_q};
                    `MFIR_IDX_CASC:   prdata <= {16'h0000, casc_q};
                    `MFIR_IDX_OUTW:   prdata <= {16'h0000, outw_q};
                    `MFIR_IDX_CFG:    prdata <= {31'h0000_0000, cfg_q};
                    `MFIR_IDX_STATUS: prdata <= {16'h0000, status};
                    default:          prdata <= 32'h0000_0000;
                endcase
                if (!addr_ok) begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/mfir_assertions.sv
// Port checker for the multirate FIR block
`timescale 1ns/1ps
`default_nettype none
module mfir_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] out_first,
    input wire logic        out_first_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_bad_addr_err: assert property (s_acc ##0 (paddr[1:0] != 2'b00) |-> pslverr)
        else $error("misaligned access not refused");
    a_word_no_wait: assert property (s_acc ##0 (paddr[11:2] < 10'd8 && paddr[1:0] == 2'b00)
        |-> pready && !pslverr) else $error("control word access stalled");
    a_sync_wait_max: assert property (s_acc ##0 !pready |-> ##[1:3] pready)
        else $error("synced write wait too long");
    a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr == 12'h020
        |=> prdata == 32'h0000_0000) else $error("unmapped read not zero");
    a_read_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    a_first_zero_idle: assert property (!out_first_valid |-> out_first == 16'h0000)
        else $error("output data without valid");
    a_quiet_reset: assert property ($rose(presetn) |-> !out_first_valid [*8])
        else $error("output right after reset");
endmodule
bind mfir_top mfir_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .out_first(out_first), .out_first_valid(out_first_valid));
`default_nettype wire

//--- testbench/mfir_source.sv
// Sample source model: phase marker, even and odd input streams
`timescale 1ns/1ps
`default_nettype none
module mfir_source (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [2:0]  period,
    input  wire logic        fire,
    input  wire logic [11:0] value,
    output logic      [11:0] in_first,
    output logic      [11:0] in_second,
    output logic             sync_in_n,
    output logic             shot
);
    logic [2:0]  phase_q;
    logic [31:0] seed = 32'h26d9_4c15;
    // Impulse only at phase 0, so the take edge is known to the bench
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q   <= 3'd0;
            in_first  <= 12'h000;
            in_second <= 12'h000;
            sync_in_n <= 1'b1;
            shot      <= 1'b0;
        end else begin
            phase_q   <= (phase_q + 3'd1 >= period) ? 3'd0 : phase_q + 3'd1;
            sync_in_n <= (phase_q != 3'd0);
            shot      <= fire && (phase_q == 3'd0);
            in_first  <= (fire && phase_q == 3'd0) ? value : 12'h000;
            in_second <= 12'($random(seed));
        end
    end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the multirate FIR block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, sync_in_n, out_first_valid, out_second_valid, shot;
    logic [11:0] in_first, in_second;
    logic [15:0] out_first, out_second;
    logic [2:0]  period = 3'd2;
    logic        fire = 1'b0;
    logic [11:0] value = 12'h000;
    logic [31:0] seed = 32'h26d9_4c15;
    int          fail_count = 0;
    int          compares = 0;
    logic [15:0] rst_tab [0:6] = '{16'h20d8, 16'h6000, 16'h00d8, 16'h6000, 16'h2000, 16'h0, 16'h0};
    logic [15:0] mode_tab [0:6] = '{16'h638b, 16'h63ab, 16'ha202, 16'h208b, 16'h2002,
                                    16'h20d8, 16'h638b};
    int          per_tab [0:6] = '{2, 2, 4, 2, 4, 1, 2};
    int          lat_tab [0:6] = '{46, 46, 50, 46, 50, 44, 62};
    int          adr_tab [0:6] = '{128, 130, 128, 128, 128, 129, 128};
    mfir_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_first(in_first), .in_second(in_second),
        .sync_in_n(sync_in_n), .out_first(out_first), .out_first_valid(out_first_valid),
        .out_second(out_second), .out_second_valid(out_second_valid));
    mfir_source src_u (.pclk(pclk), .presetn(presetn), .period(period), .fire(fire),
        .value(value), .in_first(in_first), .in_second(in_second),
        .sync_in_n(sync_in_n), .shot(shot));
    always #10 pclk = ~pclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Master holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [15:0] exp_out(input logic [11:0] x, input logic [15:0] c);
        logic signed [27:0] p;
        p = $signed(x) * $signed(c);
        return p[27:12];
    endfunction
    initial begin
        #200_000;
        fail_count++;
        complete_run();
    end
    initial begin
        logic [31:0] rd;
        logic        er;
        logic [11:0] x;
        logic [15:0] c;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0000_0000, rd, er);
            check(rd, {16'h0000, rst_tab[i]});
        end
        apb(1'b0, 12'h020, 32'h0000_0000, rd, er);
        check(er, 1'b1);
        apb(1'b0, 12'h021, 32'h0000_0000, rd, er);
        check(er, 1'b1);
        for (int i = 128; i < 192; i++) apb(1'b1, 12'(i * 4), 32'h0000_0000, rd, er);
        for (int m = 0; m < 7; m++) begin
            x = 12'($random(seed));
            c = 16'($random(seed));
            // Magnitudes kept large so the truncated product is never zero
            x = {x[11], ~x[11], x[9:0]};
            c = {c[15], ~c[15], c[13:0]};
            if (m == 0) begin
                x = 12'h800;
                c = 16'h8000;
            end
            period <= 3'(per_tab[m]);
            apb(1'b1, 12'h000, {16'h0000, mode_tab[m]}, rd, er);
            apb(1'b1, 12'h018, 32'(per_tab[m] == 4), rd, er);
            apb(1'b1, 12'h010, {16'h0000, (m == 6) ? 16'h5e00 : 16'h2000}, rd, er);
            apb(1'b1, 12'h014, (m == 5) ? 32'h0000_0048 : 32'h0000_0000, rd, er);
            apb(1'b1, 12'(adr_tab[m] * 4), {16'h0000, c}, rd, er);
            apb(1'b0, 12'h01c, 32'h0000_0000, rd, er);
            check(rd[8:0], {m == 5, m == 6,
                  7'((m == 6) ? 46 : lat_tab[m])});
            repeat (100) @(posedge pclk);
            value <= x;
            fire  <= 1'b1;
            do @(posedge pclk); while (shot !== 1'b1);
            fire <= 1'b0;
            repeat (lat_tab[m] - per_tab[m]) @(posedge pclk);
            #1;
            check(m == 6 ? out_second : out_first, 16'h0000);
            repeat (per_tab[m]) @(posedge pclk);
            #1;
            check(m == 6 ? out_second_valid : out_first_valid, 1'b1);
            check(m == 6 ? out_second : out_first,
                  exp_out(x, c));
            check({out_first_valid, out_second_valid, m == 6 ? out_first : out_second},
                  {m != 6, m != 5, 16'h0000});
            apb(1'b1, 12'(adr_tab[m] * 4), 32'h0000_0000, rd, er);
        end
        complete_run();
    end
endmodule
`default_nettype wire
